/* host_capability_registers.sv */
// Read-only capability and maximum current registers with power-on loading
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
module host_capability_registers #(
  parameter bit       USE_NVM            = 1'b0,
  parameter bit       SUSPEND_SUPPORT    = 1'b1,
  parameter bit       SINGLE_DMA_SUPPORT = 1'b1,
  parameter bit       HIGH_SPEED_SUPPORT = 1'b1,
  parameter bit       DESC_DMA_SUPPORT   = 1'b1,
  parameter bit [1:0] MAX_BLOCK_SEL      = 2'h0,
  parameter int       BASE_CLK_KHZ       = 50000,
  parameter int       TIMEOUT_CLK_KHZ    = 50000,
  parameter bit       CURRENT_BY_OTHER   = 1'b0,
  parameter int       MAX_CUR_18_MA      = 0,
  parameter int       MAX_CUR_30_MA      = 0,
  parameter int       MAX_CUR_33_MA      = 400
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] writeData,
  input  wire logic        writeStrobe,
  input  wire logic        readStrobe,
  output logic [31:0]      readData,
  input  wire logic        softResetAll,
  output logic [1:0]       nvmAddr,
  output logic             nvmRead,
  input  wire logic [31:0] nvmData,
  input  wire logic        bufAccess,
  output logic             bufReady,
  output logic             blockDone,
  output logic             capsReady,
  output logic             suspendSupported,
  output logic             singleDmaSupported,
  output logic             highSpeedSupported,
  output logic             descDmaSupported,
  output logic [1:0]       maxBlockSel
);

  // ----------------------------------------------------------------------
  // Fixed values built from parameters
  // ----------------------------------------------------------------------
  localparam logic [5:0] BASE_MHZ = host_cap_pkg::mhz_field(BASE_CLK_KHZ);
  // Up to 63 kHz the timeout clock is stated in kHz
  localparam bit         TO_IN_MHZ = (TIMEOUT_CLK_KHZ > 63);
  localparam logic [5:0] TO_FREQ   = TO_IN_MHZ ?
                                     host_cap_pkg::mhz_field(TIMEOUT_CLK_KHZ) :
                                     ((TIMEOUT_CLK_KHZ > 0) ? 6'(TIMEOUT_CLK_KHZ) : 6'h00);
  // High speed only claimed when the base clock reaches 25 MHz
  localparam bit         HS_OK    = HIGH_SPEED_SUPPORT && (BASE_CLK_KHZ >= 25000);

  localparam logic [31:0] FIXED_CAP = host_cap_pkg::clean_cap(
      (32'(SUSPEND_SUPPORT)    << host_cap_pkg::SUSPEND_BIT)    |
      (32'(SINGLE_DMA_SUPPORT) << host_cap_pkg::SINGLE_DMA_BIT) |
      (32'(HS_OK)              << host_cap_pkg::HIGH_SPEED_BIT) |
      (32'(DESC_DMA_SUPPORT)   << host_cap_pkg::DESC_DMA_BIT)   |
      (32'(MAX_BLOCK_SEL)      << host_cap_pkg::BLOCK_LSB)      |
      (32'(BASE_MHZ)           << host_cap_pkg::BASE_CLK_LSB)   |
      (32'(TO_IN_MHZ)          << host_cap_pkg::TO_UNIT_BIT)    |
      (32'(TO_FREQ)            << host_cap_pkg::TO_FREQ_LSB));

  localparam logic [31:0] FIXED_CUR = CURRENT_BY_OTHER ? 32'h00000000 :
      ((32'(host_cap_pkg::cur_field(MAX_CUR_18_MA)) << host_cap_pkg::CUR_18_LSB) |
       (32'(host_cap_pkg::cur_field(MAX_CUR_30_MA)) << host_cap_pkg::CUR_30_LSB) |
       (32'(host_cap_pkg::cur_field(MAX_CUR_33_MA)) << host_cap_pkg::CUR_33_LSB));

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [31:0] capWord_reg;
  logic [31:0] curWord_reg;
  logic [31:0] readData_reg;
  logic [31:0] readData_next;
  logic        loadError_reg;
  logic        ready_reg;
  logic        startPending_reg;

  logic        hitCapLo;
  logic        hitCapHi;
  logic        hitCurLo;
  logic        hitCurHi;
  logic        hitCtrl;
  logic        hitStat;
  logic        reloadReq;
  logic        errClear;
  logic        loadStart;
  logic        badBlock;
  logic [31:0] statusWord;
  logic [31:0] loadedCap;
  logic [31:0] loadedCur;

  nvm_load_if ld ();

  cap_loader u_loader (
    .clk     (clk),
    .rst     (rst),
    .nvmAddr (nvmAddr),
    .nvmRead (nvmRead),
    .nvmData (nvmData),
    .ld      (ld.loader)
  );

  block_counter u_block (
    .clk       (clk),
    .rst       (rst),
    .bufAccess (bufAccess),
    .blockSel  (capWord_reg[host_cap_pkg::BLOCK_LSB+:2]),
    .bufReady  (bufReady),
    .blockDone (blockDone)
  );

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  assign hitCapLo  = (addr == host_cap_pkg::CAP_LO_OFFSET);
  assign hitCapHi  = (addr == host_cap_pkg::CAP_HI_OFFSET);
  assign hitCurLo  = (addr == host_cap_pkg::CUR_LO_OFFSET);
  assign hitCurHi  = (addr == host_cap_pkg::CUR_HI_OFFSET);
  assign hitCtrl   = (addr == host_cap_pkg::LOAD_CTRL_OFFSET);
  assign hitStat   = (addr == host_cap_pkg::LOAD_STAT_OFFSET);
  assign reloadReq = writeStrobe && hitCtrl && writeData[host_cap_pkg::RELOAD_BIT];
  assign errClear  = writeStrobe && hitStat && writeData[host_cap_pkg::ERROR_BIT];

  // Loading is tied to the full software reset, to power-on and to a write of the reload bit
  assign loadStart = USE_NVM && !ld.busy &&
                     (startPending_reg || softResetAll || reloadReq);
  assign ld.start  = loadStart;

  assign loadedCap = host_cap_pkg::clean_cap(ld.capWord);
  assign loadedCur = CURRENT_BY_OTHER ? 32'h00000000 :
                     (ld.curWord & host_cap_pkg::CUR_MASK);
  assign badBlock  = ld.done &&
                     (ld.capWord[host_cap_pkg::BLOCK_LSB+:2] == host_cap_pkg::BLOCK_RSV);

  assign statusWord = {29'h0, ready_reg, loadError_reg, ld.busy};

  // Unmapped addresses and reserved upper halves read zero
  always_comb begin
    readData_next = 32'h00000000;
    if (!readStrobe) begin
      readData_next = 32'h00000000;
    end else if (hitCapLo) begin
      readData_next = capWord_reg;
    end else if (hitCapHi) begin
      readData_next = 32'h00000000;
    end else if (hitCurLo) begin
      readData_next = curWord_reg;
    end else if (hitCurHi) begin
      readData_next = 32'h00000000;
    end else if (hitStat) begin
      readData_next = statusWord;
    end else begin
      readData_next = 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Writes to capability words have no path here
  always_ff @(posedge clk) begin
    if (rst) begin
      capWord_reg <= FIXED_CAP;
      curWord_reg <= FIXED_CUR;
    end else if (ld.done) begin
      capWord_reg <= loadedCap;
      curWord_reg <= loadedCur;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readData_reg <= 32'h00000000;
    end else begin
      readData_reg <= readData_next;
    end
  end

  // One load after reset release
  always_ff @(posedge clk) begin
    if (rst) begin
      startPending_reg <= 1'b1;
    end else if (loadStart) begin
      startPending_reg <= 1'b0;
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (rst) begin
      loadError_reg <= 1'b0;
    end else if (badBlock) begin
      loadError_reg <= 1'b1;
    end else if (errClear) begin
      loadError_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ready_reg <= !USE_NVM;
    end else if (loadStart) begin
      ready_reg <= 1'b0;
    end else if (ld.done) begin
      ready_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign readData           = readData_reg;
  assign capsReady          = ready_reg;
  assign suspendSupported   = capWord_reg[host_cap_pkg::SUSPEND_BIT];
  assign singleDmaSupported = capWord_reg[host_cap_pkg::SINGLE_DMA_BIT];
  assign highSpeedSupported = capWord_reg[host_cap_pkg::HIGH_SPEED_BIT];
  assign descDmaSupported   = capWord_reg[host_cap_pkg::DESC_DMA_BIT];
  assign maxBlockSel        = capWord_reg[host_cap_pkg::BLOCK_LSB+:2];

endmodule

/* host_cap_pkg.sv */
// Constants, field layout and helper functions for the capability register bank
//
// Contract
// - Bit 23 reads 1 when suspend and resume are supported, else 0.
// - Bit 21 reads 1 only when high speed with 25 to 50 MHz clock is possible; a loaded word takes bit 21 from storage with no base clock check.
// - Bit 19 reads 1 when second-generation descriptor DMA is supported.
// - Bits 20 and 18 are reserved, fixed, and carry no new meaning.
// - Bits 17-16 give max block: 00=512, 01=1024, 10=2048, 11 reserved.
// - Data buffer moves a maximum-length block without any wait cycles.
// - Bits 13-08 give base card clock in whole MHz for divider math.
// - A fractional base clock rounds up to the next whole MHz.
// - Bit 07 gives timeout clock unit: 0 kHz, 1 MHz.
// - Bits 05-00 give timeout clock 1..63 in unit; zero means elsewhere; bit 06 reserved.
// - Max current register: 1.8V at 23-16, 3.0V at 15-08, 3.3V at 07-00.
// - Each current field is n times 4 mA up to 255; zero means elsewhere.
// - All current fields read zero when limits come by other means.
// - Capabilities register sits at 040h, 64 bits, upper half reserved.
// - Values are fixed or loaded from storage at power-on and full reset.
package host_cap_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] CAP_LO_OFFSET    = 8'h40;
  localparam logic [7:0] CAP_HI_OFFSET    = 8'h44;
  localparam logic [7:0] CUR_LO_OFFSET    = 8'h48;
  localparam logic [7:0] CUR_HI_OFFSET    = 8'h4c;
  localparam logic [7:0] LOAD_CTRL_OFFSET = 8'he0;
  localparam logic [7:0] LOAD_STAT_OFFSET = 8'he4;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int SUSPEND_BIT    = 23;
  localparam int SINGLE_DMA_BIT = 22;
  localparam int HIGH_SPEED_BIT = 21;
  localparam int DESC_DMA_BIT   = 19;
  localparam int BLOCK_LSB      = 16;
  localparam int BASE_CLK_LSB   = 8;
  localparam int TO_UNIT_BIT    = 7;
  localparam int TO_FREQ_LSB    = 0;
  localparam int CUR_18_LSB     = 16;
  localparam int CUR_30_LSB     = 8;
  localparam int CUR_33_LSB     = 0;
  localparam int RELOAD_BIT     = 0;
  localparam int BUSY_BIT       = 0;
  localparam int ERROR_BIT      = 1;
  localparam int READY_BIT      = 2;

  // Implemented bits: 23,22,21,19,17-16,13-08,07,05-00
  localparam logic [31:0] CAP_MASK  = 32'h00eb3fbf;
  localparam logic [31:0] CUR_MASK  = 32'h00ffffff;
  localparam logic [1:0]  BLOCK_512 = 2'h0;
  localparam logic [1:0]  BLOCK_RSV = 2'h3;

  // ----------------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------------
  localparam logic [31:0] WORD_RESET      = 32'h00000000;
  localparam logic [8:0]  WORDS_512       = 9'h080;
  localparam logic [1:0]  NVM_CAP_ADDR    = 2'h0;
  localparam logic [1:0]  NVM_CUR_ADDR    = 2'h1;
  localparam int          KHZ_PER_MHZ     = 1000;
  localparam int          MA_PER_STEP     = 4;

  // Whole MHz, rounded up; outside 1..63 reads as zero
  function automatic logic [5:0] mhz_field(input int khz);
    int mhz;
    mhz = (khz + KHZ_PER_MHZ - 1) / KHZ_PER_MHZ;
    if (khz <= 0 || mhz > 63) begin
      return 6'h00;
    end
    return mhz[5:0];
  endfunction

  // Steps of 4 mA, rounded down so the limit is never overstated
  function automatic logic [7:0] cur_field(input int ma);
    int steps;
    steps = ma / MA_PER_STEP;
    if (steps > 255) begin
      return 8'hff;
    end
    if (steps < 0) begin
      return 8'h00;
    end
    return steps[7:0];
  endfunction

  // Clears reserved bits and refuses the reserved block code
  function automatic logic [31:0] clean_cap(input logic [31:0] word);
    logic [31:0] w;
    w = word & CAP_MASK;
    if (w[BLOCK_LSB+:2] == BLOCK_RSV) begin
      w[BLOCK_LSB+:2] = BLOCK_512;
    end
    return w;
  endfunction

endpackage

/* nvm_load_if.sv */
// Handshake between the bank and its power-on capability loader
`timescale 1ns/10ps
interface nvm_load_if;
  logic        start;
  logic        busy;
  logic        done;
  logic [31:0] capWord;
  logic [31:0] curWord;

  modport loader (
    input  start,
    output busy,
    output done,
    output capWord,
    output curWord
  );

  modport bank (
    output start,
    input  busy,
    input  done,
    input  capWord,
    input  curWord
  );
endinterface

/* cap_loader.sv */
// Reads the two capability words from non-volatile storage
`timescale 1ns/10ps
module cap_loader (
  input  wire logic  clk,
  input  wire logic  rst,
  output logic [1:0] nvmAddr,
  output logic       nvmRead,
  input  wire logic [31:0] nvmData,
  nvm_load_if.loader ld
);

  typedef enum logic [3:0] {
    IDLE    = 4'b0001,
    GET_CAP = 4'b0010,
    GET_CUR = 4'b0100,
    FINISH  = 4'b1000
  } load_state_type;

  load_state_type state_reg;
  load_state_type state_next;
  logic [31:0]    capWord_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IDLE:    state_next = ld.start ? GET_CAP : IDLE;
      GET_CAP: state_next = GET_CUR;
      GET_CUR: state_next = FINISH;
      FINISH:  state_next = IDLE;
      default: state_next = IDLE;
    endcase
  end

  // Storage answers one cycle after the read
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg   <= IDLE;
      capWord_reg <= host_cap_pkg::WORD_RESET;
    end else begin
      state_reg <= state_next;
      if (state_reg == GET_CUR) begin
        capWord_reg <= nvmData;
      end
    end
  end

  assign nvmRead    = (state_reg == GET_CAP) || (state_reg == GET_CUR);
  assign nvmAddr    = (state_reg == GET_CUR) ? host_cap_pkg::NVM_CUR_ADDR
                                             : host_cap_pkg::NVM_CAP_ADDR;
  assign ld.busy    = (state_reg != IDLE);
  assign ld.done    = (state_reg == FINISH);
  assign ld.capWord = capWord_reg;
  // Current word is taken straight off storage in the done cycle
  assign ld.curWord = nvmData;

endmodule

/* block_counter.sv */
// Counts buffer words of one block; the buffer never stalls
`timescale 1ns/10ps
module block_counter (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       bufAccess,
  input  wire logic [1:0] blockSel,
  output logic            bufReady,
  output logic            blockDone
);

  logic [10:0] count_reg;
  logic [10:0] count_next;
  logic [10:0] lastWord;
  logic        atLast;

  assign lastWord   = ({2'h0, host_cap_pkg::WORDS_512} << blockSel) - 11'h001;
  assign atLast     = (count_reg == lastWord);
  assign count_next = atLast ? 11'h000 : count_reg + 11'h001;
  assign bufReady   = 1'b1;

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 11'h000;
      blockDone <= 1'b0;
    end else begin
      blockDone <= bufAccess && atLast;
      if (bufAccess) begin
        count_reg <= count_next;
      end
    end
  end

endmodule

/* host_capability_registers_props.sv */
// Port-level checks for the capability register bank
`timescale 1ns/10ps
module host_capability_registers_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] writeData,
  input wire logic        writeStrobe,
  input wire logic        readStrobe,
  input wire logic [31:0] readData,
  input wire logic        softResetAll,
  input wire logic [1:0]  nvmAddr,
  input wire logic        nvmRead,
  input wire logic [31:0] nvmData,
  input wire logic        bufAccess,
  input wire logic        bufReady,
  input wire logic        blockDone,
  input wire logic        capsReady,
  input wire logic        suspendSupported,
  input wire logic        singleDmaSupported,
  input wire logic        highSpeedSupported,
  input wire logic        descDmaSupported,
  input wire logic [1:0]  maxBlockSel
);
  // ----------------------------------------------------------------------
  // Word counter of one block
  // ----------------------------------------------------------------------
  logic [9:0] wordCount;
  wire  [9:0] blockWords = 10'h080 << maxBlockSel;
  wire        lastWord   = bufAccess && (wordCount == blockWords - 10'h001);
  wire        capRead    = readStrobe && (addr == host_cap_pkg::CAP_LO_OFFSET);

  always_ff @(posedge clk) begin
    if (rst) begin
      wordCount <= 10'h000;
    end else if (bufAccess) begin
      wordCount <= lastWord ? 10'h000 : wordCount + 10'h001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  chk_read_idle_zero: assert property (!readStrobe |=> readData == 32'h0)
    else $error("read data not zero outside read cycle");
  chk_cap_reserved_zero: assert property (
    capRead |=> (readData & ~host_cap_pkg::CAP_MASK) == 32'h0)
    else $error("reserved capability bit set");
  chk_block_code_legal: assert property (capRead |=> readData[17:16] != 2'h3)
    else $error("reserved block length code read");
  chk_flags_agree: assert property (capRead |=>
    readData[23:21] == {suspendSupported, singleDmaSupported, highSpeedSupported}
    && readData[19] == descDmaSupported && readData[17:16] == maxBlockSel)
    else $error("capability bits disagree with flag outputs");
  chk_high_speed_clock: assert property (
    capRead |=> !readData[21] || readData[13:8] >= 6'h19)
    else $error("high speed claimed with slow base clock");
  chk_upper_words_zero: assert property (readStrobe && (addr == 8'h44 || addr == 8'h4c)
    |=> readData == 32'h0)
    else $error("upper register word not zero");
  chk_cur_reserved_zero: assert property (
    readStrobe && addr == host_cap_pkg::CUR_LO_OFFSET |=> readData[31:24] == 8'h00)
    else $error("current register reserved bits set");
  chk_buf_no_wait: assert property (bufReady)
    else $error("buffer inserted a wait");
  chk_block_end: assert property (blockDone == $past(lastWord))
    else $error("block end pulse misplaced");
  chk_load_sequence: assert property ($rose(nvmRead) |-> nvmAddr == 2'h0
    ##1 (nvmRead && nvmAddr == 2'h1) ##1 !nvmRead ##[1:2] capsReady)
    else $error("capability load sequence wrong");

  cover property (capRead);
  cover property (blockDone);
  cover property ($rose(nvmRead));
endmodule

bind host_capability_registers host_capability_registers_props u_props (
  .clk(clk), .rst(rst), .addr(addr), .writeData(writeData), .writeStrobe(writeStrobe),
  .readStrobe(readStrobe), .readData(readData), .softResetAll(softResetAll),
  .nvmAddr(nvmAddr), .nvmRead(nvmRead), .nvmData(nvmData), .bufAccess(bufAccess),
  .bufReady(bufReady), .blockDone(blockDone), .capsReady(capsReady),
  .suspendSupported(suspendSupported), .singleDmaSupported(singleDmaSupported),
  .highSpeedSupported(highSpeedSupported), .descDmaSupported(descDmaSupported),
  .maxBlockSel(maxBlockSel));

/* testbench.sv */
// Self-checking bench for the capability register bank
`timescale 1ns/10ps
module testbench;
  logic        clk, rst, writeStrobe, readStrobe, softResetAll, bufAccess;
  logic [7:0]  addr;
  logic [31:0] writeData, nvmData, capNvm, curNvm, dutData, fixData;
  logic [5:0]  dutFlags, fixFlags;
  logic        dutReady, dutDone, fixDone, bufReady, nvmRead;
  logic [1:0]  nvmAddr;
  int          fails, checks_done, dutBlocks, fixBlocks, k;

  // ----------------------------------------------------------------------
  // Loaded instance and fixed instance share one bus
  // ----------------------------------------------------------------------
  host_capability_registers #(.USE_NVM(1'b1)) u_dut (
    .clk(clk), .rst(rst), .addr(addr), .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(dutData), .softResetAll(softResetAll),
    .nvmAddr(nvmAddr), .nvmRead(nvmRead), .nvmData(nvmData), .bufAccess(bufAccess),
    .bufReady(bufReady), .blockDone(dutDone), .capsReady(dutReady),
    .suspendSupported(dutFlags[5]), .singleDmaSupported(dutFlags[4]),
    .highSpeedSupported(dutFlags[3]), .descDmaSupported(dutFlags[2]),
    .maxBlockSel(dutFlags[1:0]));

  // High speed left enabled: a 16.5 MHz base clock must still suppress it
  // Current limits supplied elsewhere, so every current field reads zero
  host_capability_registers #(.MAX_BLOCK_SEL(2'h2), .BASE_CLK_KHZ(16500),
    .TIMEOUT_CLK_KHZ(40), .CURRENT_BY_OTHER(1'b1)) u_fix (
    .clk(clk), .rst(rst), .addr(addr), .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(fixData), .softResetAll(softResetAll),
    .nvmAddr(), .nvmRead(), .nvmData(nvmData), .bufAccess(bufAccess),
    .bufReady(), .blockDone(fixDone), .capsReady(),
    .suspendSupported(fixFlags[5]), .singleDmaSupported(fixFlags[4]),
    .highSpeedSupported(fixFlags[3]), .descDmaSupported(fixFlags[2]),
    .maxBlockSel(fixFlags[1:0]));

  // ----------------------------------------------------------------------
  // Storage model and block counting
  // ----------------------------------------------------------------------
  // Inverted data when idle, so a stale word is never captured by luck
  always @(posedge clk) begin
    nvmData <= nvmRead ? (nvmAddr == 2'h0 ? capNvm : curNvm) : ~nvmData;
  end

  always @(negedge clk) begin
    if (dutDone === 1'b1) dutBlocks++;
    if (fixDone === 1'b1) fixBlocks++;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] expV, input logic [31:0] got);
    checks_done++;
    if (got !== expV) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, expV, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    writeStrobe <= 1'b1;
    addr <= a;
    writeData <= d;
    @(posedge clk);
    writeStrobe <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] expD, input logic [31:0] expF);
    @(posedge clk);
    readStrobe <= 1'b1;
    addr <= a;
    @(posedge clk);
    readStrobe <= 1'b0;
    #1;
    check("loaded read", expD, dutData);
    check("fixed read", expF, fixData);
  endtask

  // Load walk is fixed at four cycles; eight leaves margin
  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
    check("caps ready", 32'h1, {31'h0, dutReady});
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #(3000 * 50);
    fails++;
    test_done();
  end

  initial begin
    rst = 1'b1;
    writeStrobe = 1'b0;
    readStrobe = 1'b0;
    softResetAll = 1'b0;
    bufAccess = 1'b0;
    addr = 8'h00;
    writeData = 32'h0;
    nvmData = 32'h0;
    capNvm = 32'hffffffff;
    curNvm = 32'hffffffff;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Load still running: fixed current word of 400 mA on 3.3V shows
    rd(8'h48, 32'h00000064, 32'h0);
    settle();
    rd(8'h40, 32'h00e83fbf, 32'h00ca1128);
    check("loaded flags", {26'h0, 6'h3c}, {26'h0, dutFlags});
    check("fixed flags", {26'h0, 6'h36}, {26'h0, fixFlags});
    rd(8'h44, 32'h0, 32'h0);
    rd(8'h48, 32'h00ffffff, 32'h0);
    rd(8'h4c, 32'h0, 32'h0);
    rd(8'h80, 32'h0, 32'h0);
    rd(8'he4, 32'h6, 32'h4);
    wr(8'h40, 32'h0);
    wr(8'h48, 32'h0);
    wr(8'he4, 32'h2);
    rd(8'h40, 32'h00e83fbf, 32'h00ca1128);
    rd(8'h48, 32'h00ffffff, 32'h0);
    rd(8'he4, 32'h4, 32'h4);
    for (k = 0; k < 2; k++) begin
      capNvm = k ? 32'h0 : 32'h00110a85;
      curNvm = k ? 32'h0 : 32'h12563478;
      if (k == 0) begin
        @(posedge clk);
        softResetAll <= 1'b1;
        @(posedge clk);
        softResetAll <= 1'b0;
      end else begin
        wr(8'he0, 32'h1);
      end
      settle();
      rd(8'h40, k ? 32'h0 : 32'h00010a85, 32'h00ca1128);
      check("reload flags", {26'h0, k ? 6'h00 : 6'h01}, {26'h0, dutFlags});
      rd(8'h48, k ? 32'h0 : 32'h00563478, 32'h0);
    end
    // Loaded bank now advertises 512-byte blocks, the fixed bank 2048-byte blocks
    @(posedge clk);
    bufAccess <= 1'b1;
    repeat (512) @(posedge clk);
    bufAccess <= 1'b0;
    repeat (3) @(posedge clk);
    check("loaded blocks", 32'd4, dutBlocks);
    check("fixed blocks", 32'd1, fixBlocks);
    check("buffer ready", 32'h1, {31'h0, bufReady});
    test_done();
  end
endmodule
